// ===== logic/ifsd_pkg.sv
// What this block does
// - IF feedback divides by prescaler times B plus A, prescaler on 4/5 core.
// - Control bits 1,0,1 latch the word into the IF reference divider only.
// - Doubler bit 0 feeds reference directly; 1 doubles it first.
// - Fifteen-bit IF reference divider, ratios 1 through 32767.
// - Control bits 1,1,0 load IF control; host writes zeros to test bits 13-12.
// - IF control bit 3 high holds all IF counters in reset.
// - IF charge-pump three-state bit high forces the pump to high impedance.
// - IF control bit 5 powers down IF; registers keep contents meanwhile.
// - Power-down loads counters, three-states pump, clears lock; link live.
// - IF control bit 7 selects phase detector polarity.
// - IF control bits 10 to 8 select IF charge-pump current.
// - Resync enabled only when IF control bits 15, 14 and 11 all set.
// - With resync on, each write to address 0 or 1 starts a resync.
// - Resync fires after reference cycles set by divider bits 17-3.
// - IF stays powered down until IF control, IF R, IF N, master written.
// - RF stays powered down until master, RF control, both RF words written.
// - Phase detector rate is reference times one plus doubler over divider.
// - Bits shift on rising serial clock; latch strobe rising edge transfers.
package ifsd_pkg;

    localparam int WORD_W = 24;
    localparam int ADDR_W = 3;
    localparam int RDIV_W = 15;
    localparam int ACNT_W = 6;
    localparam int BCNT_W = 13;
    localparam int PRE_W  = 8;

    // ------------------------------------------------------------
    // Address codes
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_RF_FREQ0 = 3'h0;
    localparam logic [2:0] ADDR_RF_FREQ1 = 3'h1;
    localparam logic [2:0] ADDR_RF_CTRL  = 3'h2;
    localparam logic [2:0] ADDR_MASTER   = 3'h3;
    localparam logic [2:0] ADDR_IF_NDIV  = 3'h4;
    localparam logic [2:0] ADDR_IF_RDIV  = 3'h5;
    localparam logic [2:0] ADDR_IF_CTRL  = 3'h6;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RDIV_LSB     = 3;
    localparam int RDIV_MSB     = 17;
    localparam int DOUBLER_BIT  = 18;
    localparam int CTL_CNT_RST  = 3;
    localparam int CTL_CP_TRI   = 4;
    localparam int CTL_PWR_DN   = 5;
    localparam int CTL_POL      = 7;
    localparam int CTL_CUR_LSB  = 8;
    localparam int CTL_CUR_MSB  = 10;
    localparam int CTL_RSY_A    = 11;
    localparam int CTL_TEST_LSB = 12;
    localparam int CTL_TEST_MSB = 13;
    localparam int CTL_RSY_B    = 14;
    localparam int CTL_RSY_C    = 15;
    localparam int NDIV_A_LSB   = 3;
    localparam int NDIV_A_MSB   = 8;
    localparam int NDIV_B_LSB   = 9;
    localparam int NDIV_B_MSB   = 21;
    localparam int NDIV_P_LSB   = 22;
    localparam int NDIV_P_MSB   = 23;

    // ------------------------------------------------------------
    // Reset values and prescaler core
    // ------------------------------------------------------------
    localparam logic [23:0] WORD_RST   = 24'h000000;
    localparam logic [6:0]  WRITTEN_RST = 7'h00;
    localparam logic [7:0]  PRE_CORE   = 8'h04;

endpackage

// ===== logic/ifsd_divider.sv
module ifsd_divider #(
    parameter int WIDTH = 15
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rstn_i,
    input  wire logic             hold_i,
    input  wire logic             step_i,
    input  wire logic [WIDTH-1:0] ratio_i,
    output logic                  tick_o
);

    logic [WIDTH-1:0] count;
    logic             last;

    // Ratio of zero behaves as one so the divider never stalls
    assign last = (count + {{(WIDTH-1){1'b0}}, 1'b1} >= ratio_i);

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i || hold_i) begin
            count  <= '0;
            tick_o <= 1'b0;
        end else if (step_i) begin
            if (last) begin
                count  <= '0;
                tick_o <= 1'b1;
            end else begin
                count  <= count + {{(WIDTH-1){1'b0}}, 1'b1};
                tick_o <= 1'b0;
            end
        end else begin
            tick_o <= 1'b0;
        end
    end

endmodule

// ===== logic/ifsd_top.sv
module ifsd_top (
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    input  wire logic       sclk_i,
    input  wire logic       serial_data_in_i,
    input  wire logic       latch_strobe_i,
    input  wire logic       reference_input_i,
    input  wire logic       if_feedback_input_i,
    output logic            if_ref_tick_o,
    output logic            if_feedback_tick_o,
    output logic            if_power_down_o,
    output logic            rf_power_down_o,
    output logic            if_counter_hold_o,
    output logic            if_cp_three_state_o,
    output logic            if_lock_detect_reset_o,
    output logic            if_pd_polarity_o,
    output logic [2:0]      if_cp_current_o,
    output logic [1:0]      if_test_mode_o,
    output logic            rf_resync_enable_o,
    output logic            rf_resync_pulse_o
);

    // ------------------------------------------------------------
    // Serial input register
    // ------------------------------------------------------------
    logic [ifsd_pkg::WORD_W-1:0] shift_word;
    logic                        sclk_prev;
    logic                        latch_prev;
    logic                        sclk_rise;
    logic                        latch_rise;
    logic [ifsd_pkg::ADDR_W-1:0] word_addr;

    assign sclk_rise  = sclk_i & ~sclk_prev;
    assign latch_rise = latch_strobe_i & ~latch_prev;
    assign word_addr  = shift_word[ifsd_pkg::ADDR_W-1:0];

    // Reset to the pins' idle level
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            sclk_prev  <= 1'b0;
            latch_prev <= 1'b0;
        end else begin
            sclk_prev  <= sclk_i;
            latch_prev <= latch_strobe_i;
        end
    end

    // Power-down never blocks the shifter
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            shift_word <= ifsd_pkg::WORD_RST;
        end else if (sclk_rise) begin
            shift_word <= {shift_word[ifsd_pkg::WORD_W-2:0],
                           serial_data_in_i};
        end
    end

    // ------------------------------------------------------------
    // Latched registers
    // ------------------------------------------------------------
    logic [ifsd_pkg::WORD_W-1:0] if_reference_divider;
    logic [ifsd_pkg::WORD_W-1:0] if_control;
    logic [ifsd_pkg::WORD_W-1:0] if_feedback_divider;
    logic [6:0]                  written;
    logic                        rf_freq_write;

    // IF address codes 4, 5 and 6 each load their own register
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            if_reference_divider <= ifsd_pkg::WORD_RST;
        end else if (latch_rise && word_addr == ifsd_pkg::ADDR_IF_RDIV) begin
            if_reference_divider <= shift_word;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            if_control <= ifsd_pkg::WORD_RST;
        end else if (latch_rise && word_addr == ifsd_pkg::ADDR_IF_CTRL) begin
            if_control <= shift_word;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            if_feedback_divider <= ifsd_pkg::WORD_RST;
        end else if (latch_rise && word_addr == ifsd_pkg::ADDR_IF_NDIV) begin
            if_feedback_divider <= shift_word;
        end
    end

    // Sticky record of which addresses were ever written; only reset
    // clears it, so software power-down keeps everything
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            written <= ifsd_pkg::WRITTEN_RST;
        end else if (latch_rise && word_addr <= ifsd_pkg::ADDR_IF_CTRL) begin
            written[word_addr] <= 1'b1;
        end
    end

    // Channel words for the resync timer
    assign rf_freq_write = latch_rise &&
                           (word_addr == ifsd_pkg::ADDR_RF_FREQ0 ||
                            word_addr == ifsd_pkg::ADDR_RF_FREQ1);

    // ------------------------------------------------------------
    // Section power state
    // ------------------------------------------------------------
    logic if_all_written;
    logic rf_all_written;
    logic if_pd;
    logic if_hold;
    logic if_tri;

    assign if_all_written = written[ifsd_pkg::ADDR_IF_CTRL] &
                            written[ifsd_pkg::ADDR_IF_RDIV] &
                            written[ifsd_pkg::ADDR_IF_NDIV] &
                            written[ifsd_pkg::ADDR_MASTER];
    assign rf_all_written = written[ifsd_pkg::ADDR_MASTER] &
                            written[ifsd_pkg::ADDR_RF_CTRL] &
                            written[ifsd_pkg::ADDR_RF_FREQ1] &
                            written[ifsd_pkg::ADDR_RF_FREQ0];

    assign if_pd   = ~if_all_written |
                     if_control[ifsd_pkg::CTL_PWR_DN];
    // Power-down forces hold and three-state
    assign if_hold = if_pd |
                     if_control[ifsd_pkg::CTL_CNT_RST];
    assign if_tri  = if_pd |
                     if_control[ifsd_pkg::CTL_CP_TRI];

    // Reset leaves both sections down
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            if_power_down_o        <= 1'b1;
            rf_power_down_o        <= 1'b1;
            if_counter_hold_o      <= 1'b1;
            if_cp_three_state_o    <= 1'b1;
            if_lock_detect_reset_o <= 1'b1;
        end else begin
            if_power_down_o        <= if_pd;
            rf_power_down_o        <= ~rf_all_written;
            if_counter_hold_o      <= if_hold;
            if_cp_three_state_o    <= if_tri;
            if_lock_detect_reset_o <= if_pd;
        end
    end

    // Fields lag the register by a cycle
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            if_pd_polarity_o <= 1'b0;
            if_cp_current_o  <= 3'h0;
            if_test_mode_o   <= 2'h0;
        end else begin
            if_pd_polarity_o <= if_control[ifsd_pkg::CTL_POL];
            if_cp_current_o  <= if_control[ifsd_pkg::CTL_CUR_MSB:
                                           ifsd_pkg::CTL_CUR_LSB];
            // Passed through untouched; zero is the host's duty
            if_test_mode_o   <= if_control[ifsd_pkg::CTL_TEST_MSB:
                                           ifsd_pkg::CTL_TEST_LSB];
        end
    end

    // ------------------------------------------------------------
    // Reference path
    // ------------------------------------------------------------
    logic                         ref_prev;
    logic                         ref_rise;
    logic                         ref_fall;
    logic                         ref_step;
    logic [ifsd_pkg::RDIV_W-1:0]  r_ratio;

    assign ref_rise = reference_input_i & ~ref_prev;
    assign ref_fall = ~reference_input_i & ref_prev;
    // Doubling uses both edges, so duty cycle sets the doubled spacing
    assign ref_step = if_reference_divider[ifsd_pkg::DOUBLER_BIT] ?
                      (ref_rise | ref_fall) : ref_rise;
    assign r_ratio  = if_reference_divider[ifsd_pkg::RDIV_MSB:
                                           ifsd_pkg::RDIV_LSB];

    // Limit: inputs below half the clock rate
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            ref_prev <= 1'b0;
        end else begin
            ref_prev <= reference_input_i;
        end
    end

    logic r_tick;

    // Ratio 0 behaves as 1
    ifsd_divider #(
        .WIDTH (ifsd_pkg::RDIV_W)
    ) u_ref_div (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .hold_i    (if_hold),
        .step_i    (ref_step),
        .ratio_i   (r_ratio),
        .tick_o    (r_tick)
    );

    // ------------------------------------------------------------
    // Feedback path: pulse-swallow dual-modulus divider
    // ------------------------------------------------------------
    logic                         fb_prev;
    logic                         fb_rise;
    logic [ifsd_pkg::ACNT_W-1:0]  a_val;
    logic [ifsd_pkg::BCNT_W-1:0]  b_val;
    logic [1:0]                   p_sel;
    logic [ifsd_pkg::PRE_W-1:0]   p_val;
    logic [ifsd_pkg::PRE_W-1:0]   pre_ratio;
    logic [ifsd_pkg::ACNT_W-1:0]  a_count;
    logic                         swallow;
    logic                         pre_tick;
    logic                         b_tick;

    assign fb_rise = if_feedback_input_i & ~fb_prev;
    assign a_val   = if_feedback_divider[ifsd_pkg::NDIV_A_MSB:
                                         ifsd_pkg::NDIV_A_LSB];
    assign b_val   = if_feedback_divider[ifsd_pkg::NDIV_B_MSB:
                                         ifsd_pkg::NDIV_B_LSB];
    assign p_sel   = if_feedback_divider[ifsd_pkg::NDIV_P_MSB:
                                         ifsd_pkg::NDIV_P_LSB];
    // Prescaler grows from the 4/5 core by doubling stages
    assign p_val     = ifsd_pkg::PRE_CORE << p_sel;
    assign swallow   = (a_count < a_val);
    assign pre_ratio = p_val + {{(ifsd_pkg::PRE_W-1){1'b0}}, swallow};

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            fb_prev <= 1'b0;
        end else begin
            fb_prev <= if_feedback_input_i;
        end
    end

    ifsd_divider #(
        .WIDTH (ifsd_pkg::PRE_W)
    ) u_prescaler (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .hold_i    (if_hold),
        .step_i    (fb_rise),
        .ratio_i   (pre_ratio),
        .tick_o    (pre_tick)
    );

    ifsd_divider #(
        .WIDTH (ifsd_pkg::BCNT_W)
    ) u_b_div (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .hold_i    (if_hold),
        .step_i    (pre_tick),
        .ratio_i   (b_val),
        .tick_o    (b_tick)
    );

    // A counts modulus P+1 cycles, then P runs out the remaining B-A
    // Limit: needs A no larger than B
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i || if_hold) begin
            a_count <= '0;
        end else if (b_tick) begin
            a_count <= '0;
        end else if (pre_tick && swallow) begin
            a_count <= a_count + {{(ifsd_pkg::ACNT_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            if_ref_tick_o <= 1'b0;
        end else begin
            if_ref_tick_o <= r_tick & ~if_hold;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            if_feedback_tick_o <= 1'b0;
        end else begin
            if_feedback_tick_o <= b_tick & ~if_hold;
        end
    end

    // ------------------------------------------------------------
    // RF phase resync timer
    // ------------------------------------------------------------
    logic                        resync_en;
    logic                        resync_busy;
    logic [ifsd_pkg::RDIV_W-1:0] resync_count;

    // All three bits must be set
    assign resync_en = if_control[ifsd_pkg::CTL_RSY_C] &
                       if_control[ifsd_pkg::CTL_RSY_B] &
                       if_control[ifsd_pkg::CTL_RSY_A];

    // A fresh channel write restarts the wait; counts plain
    // reference edges, the doubler does not apply here
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            resync_busy       <= 1'b0;
            resync_count      <= '0;
            rf_resync_pulse_o <= 1'b0;
        end else if (!resync_en) begin
            resync_busy       <= 1'b0;
            resync_count      <= '0;
            rf_resync_pulse_o <= 1'b0;
        end else if (rf_freq_write) begin
            resync_busy       <= 1'b1;
            resync_count      <= '0;
            rf_resync_pulse_o <= 1'b0;
        end else if (resync_busy && ref_rise) begin
            if (resync_count + {{(ifsd_pkg::RDIV_W-1){1'b0}}, 1'b1}
                >= r_ratio) begin
                resync_busy       <= 1'b0;
                resync_count      <= '0;
                rf_resync_pulse_o <= 1'b1;
            end else begin
                resync_count      <= resync_count +
                    {{(ifsd_pkg::RDIV_W-1){1'b0}}, 1'b1};
                rf_resync_pulse_o <= 1'b0;
            end
        end else begin
            rf_resync_pulse_o <= 1'b0;
        end
    end

    // Lets the RF side gate its resync
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            rf_resync_enable_o <= 1'b0;
        end else begin
            rf_resync_enable_o <= resync_en;
        end
    end

endmodule

// ===== verif/ifsd_host_model.sv
module ifsd_host_model (
    input  wire logic clk_sys_i,
    output logic      sclk_o,
    output logic      sdo_o,
    output logic      latch_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sclk_o  = 1'b0;
        sdo_o   = 1'b1;
        latch_o = 1'b0;
    end

    // ------------------------------------------------------------
    // Word transfer, MSB first
    // ------------------------------------------------------------
    // Two cycles per level so every edge is seen by the sampler
    task automatic send(input logic [23:0] word);
        for (int i = 23; i >= 0; i--) begin
            @(posedge clk_sys_i);
            #1;
            sclk_o  = 1'b0;
            sdo_o   = word[i];
            repeat (2) @(posedge clk_sys_i);
            #1 sclk_o = 1'b1;
            repeat (1) @(posedge clk_sys_i);
        end
        @(posedge clk_sys_i);
        #1;
        sclk_o  = 1'b0;
        sdo_o   = ~word[0];
        repeat (2) @(posedge clk_sys_i);
        #1 latch_o = 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #1 latch_o = 1'b0;
    endtask
endmodule

// ===== verif/ifsd_top_monitor.sv
module ifsd_top_monitor (
    input wire logic       clk_sys_i,
    input wire logic       rstn_i,
    input wire logic       latch_strobe_i,
    input wire logic       if_ref_tick_o,
    input wire logic       if_feedback_tick_o,
    input wire logic       if_power_down_o,
    input wire logic       rf_power_down_o,
    input wire logic       if_counter_hold_o,
    input wire logic       if_cp_three_state_o,
    input wire logic       if_lock_detect_reset_o,
    input wire logic       if_pd_polarity_o,
    input wire logic [2:0] if_cp_current_o,
    input wire logic       rf_resync_enable_o,
    input wire logic       rf_resync_pulse_o
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence recent_latch;
        $past(latch_strobe_i, 1) || $past(latch_strobe_i, 2)
            || $past(latch_strobe_i, 3);
    endsequence

    a_down_at_release: assert property ($rose(rstn_i) |->
        if_power_down_o && rf_power_down_o && if_cp_three_state_o)
        else $error("sections not held down at reset release");
    a_pd_forces_load: assert property (if_power_down_o |->
        if_counter_hold_o && if_cp_three_state_o)
        else $error("power-down without hold and three-state");
    a_lock_reset_pd: assert property (
        if_lock_detect_reset_o == if_power_down_o)
        else $error("lock detect reset differs from power-down");
    a_hold_no_ticks: assert property (if_counter_hold_o [*4] |->
        !if_ref_tick_o && !if_feedback_tick_o)
        else $error("divider tick while counters held");
    a_ref_tick_pulse: assert property (if_ref_tick_o |=>
        !if_ref_tick_o)
        else $error("reference tick longer than one cycle");
    a_fields_on_latch: assert property (
        ($changed(if_cp_current_o) || $changed(if_pd_polarity_o))
        |-> recent_latch)
        else $error("control field changed without a latch");
    a_rf_up_latch: assert property ($fell(rf_power_down_o) |->
        recent_latch)
        else $error("RF left power-down without a latch");
    a_resync_gated: assert property (rf_resync_pulse_o |->
        rf_resync_enable_o || $past(rf_resync_enable_o))
        else $error("resync pulse while disabled");
    a_resync_single: assert property (rf_resync_pulse_o |=>
        !rf_resync_pulse_o)
        else $error("resync pulse longer than one cycle");

    c_resync: cover property (rf_resync_pulse_o);
    c_ref_tick: cover property (if_ref_tick_o);
    c_fb_tick: cover property (if_feedback_tick_o);
    c_if_up: cover property ($fell(if_power_down_o));
endmodule

bind ifsd_top ifsd_top_monitor ifsd_top_monitor_inst (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .latch_strobe_i(latch_strobe_i), .if_ref_tick_o(if_ref_tick_o),
    .if_feedback_tick_o(if_feedback_tick_o),
    .if_power_down_o(if_power_down_o), .rf_power_down_o(rf_power_down_o),
    .if_counter_hold_o(if_counter_hold_o),
    .if_cp_three_state_o(if_cp_three_state_o),
    .if_lock_detect_reset_o(if_lock_detect_reset_o),
    .if_pd_polarity_o(if_pd_polarity_o), .if_cp_current_o(if_cp_current_o),
    .rf_resync_enable_o(rf_resync_enable_o),
    .rf_resync_pulse_o(rf_resync_pulse_o)
);

// ===== verif/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int LIMIT = 20000;

    logic       clk_sys_i;
    logic       rstn_i;
    logic       ref_in;
    logic       fb_in;
    wire logic  sclk;
    wire logic  sdo;
    wire logic  latch;
    logic       ref_tick, fb_tick, if_pd, rf_pd, hold, tri_st, lock_rst;
    logic       pol, rsy_en, rsy_pulse;
    logic [2:0] cur;
    logic [1:0] test;
    int         failures, check_count, cycles, n_ref, n_fb, n;

    ifsd_host_model ifsd_host_model_inst (.clk_sys_i(clk_sys_i),
        .sclk_o(sclk), .sdo_o(sdo), .latch_o(latch));

    ifsd_top ifsd_top_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .sclk_i(sclk), .serial_data_in_i(sdo), .latch_strobe_i(latch),
        .reference_input_i(ref_in), .if_feedback_input_i(fb_in),
        .if_ref_tick_o(ref_tick), .if_feedback_tick_o(fb_tick),
        .if_power_down_o(if_pd), .rf_power_down_o(rf_pd),
        .if_counter_hold_o(hold), .if_cp_three_state_o(tri_st),
        .if_lock_detect_reset_o(lock_rst), .if_pd_polarity_o(pol),
        .if_cp_current_o(cur), .if_test_mode_o(test),
        .rf_resync_enable_o(rsy_en), .rf_resync_pulse_o(rsy_pulse));

    // ------------------------------------------------------------
    // Clocks, counters and timeout
    // ------------------------------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    // Reference period 8 cycles, feedback period 6 cycles
    initial begin
        ref_in = 1'b0;
        forever begin
            repeat (4) @(posedge clk_sys_i);
            #1 ref_in = ~ref_in;
        end
    end
    initial begin
        fb_in = 1'b0;
        forever begin
            repeat (3) @(posedge clk_sys_i);
            #1 fb_in = ~fb_in;
        end
    end
    always @(posedge clk_sys_i) begin
        if (ref_tick === 1'b1) n_ref++;
        if (fb_tick === 1'b1) n_fb++;
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            $display("[ERR] %0t run did not finish in time", $time);
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            failures++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic give_verdict();
        $display("Checks: %0d  mismatches: %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic do_reset();
        rstn_i = 1'b0;
        repeat (20) @(posedge clk_sys_i);
        #1 rstn_i = 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wr(input logic [23:0] w);
        ifsd_host_model_inst.send(w);
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic measure(input int cyc);
        n_ref = 0;
        n_fb  = 0;
        repeat (cyc) @(posedge clk_sys_i);
        #1;
    endtask
    function automatic logic near(input int v, input int e);
        return v >= e - 1 && v <= e + 1;
    endfunction
    // Index of the cycle with the resync pulse, -1 if none
    task automatic wait_pulse();
        n = -1;
        for (int i = 0; i < 70; i++) begin
            @(posedge clk_sys_i);
            #1;
            if (rsy_pulse === 1'b1 && n < 0) n = i;
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_state();
        chk(if_pd === 1'b1 && rf_pd === 1'b1 && hold === 1'b1
            && tri_st === 1'b1, "sections not down after reset");
        chk(cur === 3'h0 && rsy_en === 1'b0, "fields not cleared");
    endtask
    task automatic t_power_up();
        wr(24'h000586);
        chk(if_pd === 1'b1, "IF up after one write");
        wr(24'h00001d);
        chk(if_pd === 1'b1, "IF up after two writes");
        wr(24'h00040c);
        chk(if_pd === 1'b1, "IF up after three writes");
        wr(24'h000003);
        chk(if_pd === 1'b0 && rf_pd === 1'b1, "power-up gating");
        chk(pol === 1'b1 && cur === 3'h5 && test === 2'h0, "ctrl");
        wr(24'h000002);
        wr(24'h000001);
        chk(rf_pd === 1'b1, "RF up before frequency word 0");
        wr(24'h000000);
        chk(rf_pd === 1'b0, "RF still down");
    endtask
    task automatic t_divide();
        measure(480);
        chk(near(n_ref, 20), "reference ratio 3");
        wr(24'h04001d);
        measure(480);
        chk(near(n_ref, 40), "doubled reference ratio 3");
        wr(24'h00000d);
        measure(480);
        chk(near(n_ref, 60), "reference ratio 1");
        for (int s = 0; s < 4; s++) begin
            wr({2'(s), 13'h0002, 6'h01, 3'h4});
            measure(960);
            chk(near(n_fb, 960 / (6 * ((4 << s) * 2 + 1))), "N ratio");
        end
    endtask
    task automatic t_hold_tri();
        wr(24'h00058e);
        chk(hold === 1'b1 && tri_st === 1'b0, "counter reset");
        measure(200);
        chk(n_ref == 0 && n_fb == 0, "ticks while held");
        wr(24'h000596);
        chk(tri_st === 1'b1 && hold === 1'b0, "three-state");
        wr(24'h000586);
        chk(tri_st === 1'b0 && hold === 1'b0, "normal drive");
    endtask
    task automatic t_power_down();
        wr(24'h0005a6);
        chk(if_pd === 1'b1 && hold === 1'b1 && tri_st === 1'b1
            && lock_rst === 1'b1, "power-down effects");
        chk(cur === 3'h5 && pol === 1'b1, "fields lost");
        measure(200);
        chk(n_ref == 0, "ticks while powered down");
        wr(24'h000025);
        wr(24'h000586);
        chk(if_pd === 1'b0 && lock_rst === 1'b0, "power restore");
        measure(480);
        chk(near(n_ref, 15), "word lost during power-down");
    endtask
    task automatic t_bad_addr();
        wr(24'h000007);
        chk(cur === 3'h5 && pol === 1'b1 && if_pd === 1'b0, "addr 7");
        measure(480);
        chk(near(n_ref, 15), "ratio changed by addr 7");
    endtask
    task automatic t_resync();
        wr(24'h00c586);
        chk(rsy_en === 1'b0, "resync on with two bits");
        wr(24'h00cd86);
        chk(rsy_en === 1'b1, "resync not enabled");
        wr(24'h000035);
        for (int a = 0; a < 3; a++) begin
            ifsd_host_model_inst.send({21'h0, 3'(a)});
            wait_pulse();
            if (a == 2) begin
                chk(n < 0, "resync on RF control write");
            end else begin
                chk(n >= 39 && n <= 46, "resync delay");
            end
        end
        wr(24'h000586);
        ifsd_host_model_inst.send(24'h000000);
        wait_pulse();
        chk(n < 0, "resync while disabled");
    endtask

    initial begin
        failures    = 0;
        check_count = 0;
        cycles      = 0;
        n_ref       = 0;
        n_fb        = 0;
        rstn_i      = 1'b0;
        do_reset();
        t_reset_state();
        t_power_up();
        t_divide();
        t_hold_tri();
        t_power_down();
        t_bad_addr();
        t_resync();
        do_reset();
        t_reset_state();
        give_verdict();
    end
endmodule
